// >>> src/cod_opcode_decoder.sv
`timescale 1ns/10ps
// ****************************************************************
// primary opcode decoder, architecture levels one to four
// ****************************************************************
// How it works
// - opcode bits 31..26: row 31..29, column 28..26
// - row 000: classes, jumps, four compare branches
// - row 001: immediate arithmetic, logic, load upper
// - row 010 coprocessor classes; rows 110/111 coprocessor word load/store
// - rows 100/101: byte, half, word loads, stores
// - level one: coprocessor word load/store only
// - level two adds likely branches, linked, doubles
// - function row 000: shifts, columns 1,5 empty
// - function row 001: jumps, call, breakpoint, sync
// - function rows 010/011: hi/lo moves, multiply, divide
// - function rows 100/101: add, sub, logic, set-less
// - level two function row 110: conditional traps
// - reg-imm class decodes rt bits 20..16
// - level three on: no coprocessor 3 opcodes
// - level four: coproc3_class slot becomes fpu extended
// - secondary field used only for class opcodes
// - input is one aligned 32-bit word
// - second-level mode still accepts coprocessor 3 opcodes
module cod_opcode_decoder (
  // clock and reset, only for sampling the checks
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // instruction and level setting
  input wire logic [31:0] INSTR_IN,
  input wire cod_pkg::cod_level_t LEVEL_IN,
  // decode results to the pipeline
  output cod_pkg::cod_op_t OP_OUT,
  output logic [1:0] COP_NUM_OUT,
  output logic RESERVED_OUT
);
  import cod_pkg::*;

  // ****************************************************************
  // field split
  // ****************************************************************
  logic [5:0] opc; // primary opcode
  logic [2:0] opc_row; // opcode row
  logic [2:0] opc_col; // opcode column
  logic [1:0] rt_row; // reg-imm row
  logic [2:0] rt_col; // reg-imm column
  logic lvl_two_plus; // level two or later
  logic coproc3_class_allowed; // coprocessor 3 exists only at levels one and two
  cod_op_t func_op; // register class result
  logic func_rsv; // register class hole
  cod_op_t op_dec; // combined result
  logic [1:0] cop_dec; // coprocessor number
  logic rsv_dec; // reserved result

  assign opc = INSTR_IN[OPC_HI:OPC_LO];
  assign opc_row = INSTR_IN[OPC_ROW_HI:OPC_ROW_LO];
  assign opc_col = INSTR_IN[OPC_COL_HI:OPC_COL_LO];
  assign rt_row = INSTR_IN[RT_ROW_HI:RT_ROW_LO];
  assign rt_col = INSTR_IN[RT_COL_HI:RT_COL_LO];
  assign lvl_two_plus = (LEVEL_IN != lvl_one);
  // later levels in any mode drop coprocessor 3
  assign coproc3_class_allowed = (LEVEL_IN == lvl_one) || (LEVEL_IN == lvl_two);

  // the function table lives in its own leaf
  cod_func_decoder u_func (
    .func_in(INSTR_IN[FUNC_ROW_HI:FUNC_COL_LO]),
    .level_in(LEVEL_IN),
    .op_out(func_op),
    .reserved_out(func_rsv)
  );

  // ****************************************************************
  // decode; no register stage so the answer is ready the same cycle
  // ****************************************************************
  always_comb begin
    op_dec = op_none;
    cop_dec = opc_col[1:0];
    case (opc_row)
      ROW_0: begin
        case (opc_col)
          3'h0: op_dec = func_op;
          3'h1: begin
            // only the rt field distinguishes the reg-imm branches
            if (rt_row == RT_ROW_PLAIN && rt_col == 3'h0) begin
              op_dec = op_branch_lt_zero;
            end else if (rt_row == RT_ROW_PLAIN && rt_col == 3'h1) begin
              op_dec = op_branch_ge_zero;
            end else if (rt_row == RT_ROW_LINK && rt_col == 3'h0) begin
              op_dec = op_branch_lt_zero_link;
            end else if (rt_row == RT_ROW_LINK && rt_col == 3'h1) begin
              op_dec = op_branch_ge_zero_link;
            end else begin
              op_dec = op_none; // likely and trap-immediate forms left out
            end
          end
          3'h2: op_dec = op_jump_abs;
          3'h3: op_dec = op_jump_abs_link;
          3'h4: op_dec = op_branch_equal;
          3'h5: op_dec = op_branch_not_equal;
          3'h6: op_dec = op_branch_le_zero;
          default: op_dec = op_branch_gt_zero;
        endcase
      end
      ROW_1: begin
        case (opc_col)
          3'h0: op_dec = op_add_imm_trapping;
          3'h1: op_dec = op_add_imm_wrapping;
          3'h2: op_dec = op_set_less_imm;
          3'h3: op_dec = op_set_less_imm_unsigned;
          3'h4: op_dec = op_and_imm;
          3'h5: op_dec = op_or_imm;
          3'h6: op_dec = op_xor_imm;
          default: op_dec = op_load_upper_imm;
        endcase
      end
      ROW_2: begin
        case (opc_col)
          3'h0: op_dec = op_coproc0_class;
          3'h1: op_dec = op_coproc1_class;
          3'h2: op_dec = op_coproc2_class;
          3'h3: begin
            // the coproc3_class slot is reused at level four
            if (coproc3_class_allowed) begin
              op_dec = op_coproc3_class;
            end else if (LEVEL_IN == lvl_four) begin
              op_dec = op_fpu_extended_class;
            end else begin
              op_dec = op_none;
            end
          end
          default: begin
            // likely branches mirror row 000 columns 4..7
            if (!lvl_two_plus) begin
              op_dec = op_none;
            end else if (opc_col == 3'h4) begin
              op_dec = op_branch_equal_likely;
            end else if (opc_col == 3'h5) begin
              op_dec = op_branch_not_equal_likely;
            end else if (opc_col == 3'h6) begin
              op_dec = op_branch_le_zero_likely;
            end else begin
              op_dec = op_branch_gt_zero_likely;
            end
          end
        endcase
      end
      ROW_3: op_dec = op_none;
      ROW_4: begin
        case (opc_col)
          3'h0: op_dec = op_load_byte;
          3'h1: op_dec = op_load_half;
          3'h2: op_dec = op_load_word_left;
          3'h3: op_dec = op_load_word;
          3'h4: op_dec = op_load_byte_unsigned;
          3'h5: op_dec = op_load_half_unsigned;
          3'h6: op_dec = op_load_word_right;
          default: op_dec = op_none;
        endcase
      end
      ROW_5: begin
        case (opc_col)
          3'h0: op_dec = op_store_byte;
          3'h1: op_dec = op_store_half;
          3'h2: op_dec = op_store_word_left;
          3'h3: op_dec = op_store_word;
          3'h6: op_dec = op_store_word_right;
          default: op_dec = op_none; // column 7 is privileged, not decoded here
        endcase
      end
      default: begin
        // rows 110 (loads) and 111 (stores) share one column layout
        case (opc_col)
          3'h0: begin
            if (lvl_two_plus) begin
              op_dec = (opc_row == ROW_6) ? op_load_linked : op_store_conditional;
            end
          end
          3'h1, 3'h2: begin
            op_dec = (opc_row == ROW_6) ? op_cop_load_word : op_cop_store_word;
          end
          3'h3: begin
            if (coproc3_class_allowed) begin
              op_dec = (opc_row == ROW_6) ? op_cop_load_word : op_cop_store_word;
            end
          end
          3'h5, 3'h6: begin
            if (lvl_two_plus) begin
              op_dec = (opc_row == ROW_6) ? op_cop_load_double : op_cop_store_double;
            end
          end
          3'h7: begin
            // coproc3_class doubles only at level two
            if (LEVEL_IN == lvl_two) begin
              op_dec = (opc_row == ROW_6) ? op_cop_load_double : op_cop_store_double;
            end
          end
          default: op_dec = op_none;
        endcase
      end
    endcase
    if (op_dec == op_none) begin
      cop_dec = 2'h0;
    end
  end

  // a hole anywhere, function holes included, reads as reserved
  assign rsv_dec = (op_dec == op_none);
  assign OP_OUT = op_dec;
  assign COP_NUM_OUT = cop_dec;
  assign RESERVED_OUT = rsv_dec;

  // ****************************************************************
  // checks
  // ****************************************************************
  // the coproc3_class class slot seen at each later level
  sequence s_coproc3_class_at_three;
    (opc == OPC_COPROC3_CLASS_SLOT && LEVEL_IN == lvl_three);
  endsequence
  sequence s_coproc3_class_at_four;
    (opc == OPC_COPROC3_CLASS_SLOT && LEVEL_IN == lvl_four);
  endsequence

  a_coproc3_class_withdrawn: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_coproc3_class_at_three |-> RESERVED_OUT)
    else $error("coproc3_class slot decoded at level three");
  a_fpu_ext_slot: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_coproc3_class_at_four |-> OP_OUT == op_fpu_extended_class)
    else $error("level four coproc3_class slot not fpu extended");
  a_coproc3_class_levels: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (OP_OUT == op_cop_load_word || OP_OUT == op_cop_store_word
     || OP_OUT == op_cop_load_double || OP_OUT == op_cop_store_double)
    && COP_NUM_OUT == 2'h3
    |-> LEVEL_IN == lvl_one || LEVEL_IN == lvl_two)
    else $error("coproc3_class load or store passed at a later level");
  a_reserved_none: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    opc == OPC_REG_CLASS && INSTR_IN[FUNC_ROW_HI:FUNC_COL_LO] == 6'h01
    |-> RESERVED_OUT && OP_OUT == op_none && COP_NUM_OUT == 2'h0)
    else $error("function hole not refused");
  a_level_one_ll: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (LEVEL_IN == lvl_one) && (opc_row == ROW_6 || opc_row == ROW_7) && opc_col == 3'h0
    |-> RESERVED_OUT)
    else $error("linked access accepted at level one");
  a_func_only_class: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (OP_OUT == op_logic_nor || OP_OUT == op_jump_register) |-> opc == OPC_REG_CLASS)
    else $error("function op without register class");
  a_reg_imm_class_link: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    opc == OPC_REG_IMM && {rt_row, rt_col} == 5'h11 |-> OP_OUT == op_branch_ge_zero_link)
    else $error("reg-imm linking branch misdecoded");
  a_trap_level: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    opc == OPC_REG_CLASS && INSTR_IN[FUNC_ROW_HI:FUNC_COL_LO] == 6'h34
    |-> (OP_OUT == op_trap_equal) == (LEVEL_IN != lvl_one))
    else $error("trap equal level gating wrong");
  a_no_state: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $stable(INSTR_IN) && $stable(LEVEL_IN) |-> $stable(OP_OUT) && $stable(RESERVED_OUT))
    else $error("output moved with inputs held");
  a_likely_branch: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    opc == 6'h14 |-> (OP_OUT == op_branch_equal_likely) == (LEVEL_IN != lvl_one))
    else $error("likely branch level gating wrong");

endmodule // cod_opcode_decoder

// >>> shared/cod_pkg.sv
// ****************************************************************
// decoder package: field positions, table rows, levels, operations
// ****************************************************************
package cod_pkg;

  // instruction word layout
  localparam int INSTR_W = 32; // one aligned instruction word
  localparam int OPC_HI = 31; // primary opcode field
  localparam int OPC_LO = 26;
  localparam int OPC_ROW_HI = 31; // table row of the primary opcode
  localparam int OPC_ROW_LO = 29;
  localparam int OPC_COL_HI = 28; // table column of the primary opcode
  localparam int OPC_COL_LO = 26;
  localparam int RT_ROW_HI = 20; // rt field row, used by the reg-imm class
  localparam int RT_ROW_LO = 19;
  localparam int RT_COL_HI = 18;
  localparam int RT_COL_LO = 16;
  localparam int FUNC_ROW_HI = 5; // function field row
  localparam int FUNC_ROW_LO = 3;
  localparam int FUNC_COL_HI = 2;
  localparam int FUNC_COL_LO = 0;

  // table rows, shared by the opcode and function tables
  localparam logic [2:0] ROW_0 = 3'h0;
  localparam logic [2:0] ROW_1 = 3'h1;
  localparam logic [2:0] ROW_2 = 3'h2;
  localparam logic [2:0] ROW_3 = 3'h3;
  localparam logic [2:0] ROW_4 = 3'h4;
  localparam logic [2:0] ROW_5 = 3'h5;
  localparam logic [2:0] ROW_6 = 3'h6;
  localparam logic [2:0] ROW_7 = 3'h7;

  // rt rows of the reg-imm class
  localparam logic [1:0] RT_ROW_PLAIN = 2'h0;
  localparam logic [1:0] RT_ROW_LINK = 2'h2;

  // opcodes that name a class or a reused slot
  localparam logic [5:0] OPC_REG_CLASS = 6'h00;
  localparam logic [5:0] OPC_REG_IMM = 6'h01;
  localparam logic [5:0] OPC_COPROC3_CLASS_SLOT = 6'h13;

  // architecture level setting
  typedef enum logic [1:0] {
    lvl_one,
    lvl_two,
    lvl_three,
    lvl_four
  } cod_level_t;

  // decoded instruction identity
  typedef enum logic [6:0] {
    op_none,
    op_jump_abs, op_jump_abs_link,
    op_branch_equal, op_branch_not_equal, op_branch_le_zero, op_branch_gt_zero,
    op_add_imm_trapping, op_add_imm_wrapping, op_set_less_imm,
    op_set_less_imm_unsigned, op_and_imm, op_or_imm, op_xor_imm,
    op_load_upper_imm,
    op_coproc0_class, op_coproc1_class, op_coproc2_class, op_coproc3_class,
    op_fpu_extended_class,
    op_branch_equal_likely, op_branch_not_equal_likely,
    op_branch_le_zero_likely, op_branch_gt_zero_likely,
    op_load_byte, op_load_half, op_load_word_left, op_load_word,
    op_load_byte_unsigned, op_load_half_unsigned, op_load_word_right,
    op_store_byte, op_store_half, op_store_word_left, op_store_word,
    op_store_word_right,
    op_load_linked, op_store_conditional,
    op_cop_load_word, op_cop_store_word, op_cop_load_double, op_cop_store_double,
    op_shift_left_logical, op_shift_right_logical, op_shift_right_arith,
    op_shift_left_logical_var, op_shift_right_logical_var, op_shift_right_arith_var,
    op_jump_register, op_jump_register_link, op_system_call, op_breakpoint,
    op_memory_sync,
    op_move_from_hi, op_move_to_hi, op_move_from_lo, op_move_to_lo,
    op_multiply, op_multiply_unsigned, op_divide, op_divide_unsigned,
    op_add_trapping, op_add_wrapping, op_sub_trapping, op_sub_wrapping,
    op_logic_and, op_logic_or, op_logic_xor, op_logic_nor,
    op_set_less, op_set_less_unsigned,
    op_trap_greater_equal, op_trap_ge_unsigned, op_trap_less,
    op_trap_less_unsigned, op_trap_equal, op_trap_not_equal,
    op_branch_lt_zero, op_branch_ge_zero, op_branch_lt_zero_link,
    op_branch_ge_zero_link
  } cod_op_t;

endpackage

// >>> src/cod_func_decoder.sv
`timescale 1ns/10ps
// ****************************************************************
// function field decoder for the register class
// ****************************************************************
module cod_func_decoder (
  // function field and level
  input wire logic [5:0] func_in,
  input wire cod_pkg::cod_level_t level_in,
  // decoded result
  output cod_pkg::cod_op_t op_out,
  output logic reserved_out
);
  import cod_pkg::*;

  logic [2:0] row; // function row, bits 5..3
  logic [2:0] col; // function column, bits 2..0
  logic lvl_two_plus; // sync and traps exist from level two on

  assign row = func_in[FUNC_ROW_HI:FUNC_ROW_LO];
  assign col = func_in[FUNC_COL_HI:FUNC_COL_LO];
  assign lvl_two_plus = (level_in != lvl_one);

  // table lookup; any hole falls through to reserved
  always_comb begin
    op_out = op_none;
    case (row)
      ROW_0: begin
        case (col)
          3'h0: op_out = op_shift_left_logical;
          3'h2: op_out = op_shift_right_logical;
          3'h3: op_out = op_shift_right_arith;
          3'h4: op_out = op_shift_left_logical_var;
          3'h6: op_out = op_shift_right_logical_var;
          3'h7: op_out = op_shift_right_arith_var;
          default: op_out = op_none;
        endcase
      end
      ROW_1: begin
        case (col)
          3'h0: op_out = op_jump_register;
          3'h1: op_out = op_jump_register_link;
          3'h4: op_out = op_system_call;
          3'h5: op_out = op_breakpoint;
          3'h7: op_out = lvl_two_plus ? op_memory_sync : op_none;
          default: op_out = op_none;
        endcase
      end
      ROW_2: begin
        case (col)
          3'h0: op_out = op_move_from_hi;
          3'h1: op_out = op_move_to_hi;
          3'h2: op_out = op_move_from_lo;
          3'h3: op_out = op_move_to_lo;
          default: op_out = op_none;
        endcase
      end
      ROW_3: begin
        case (col)
          3'h0: op_out = op_multiply;
          3'h1: op_out = op_multiply_unsigned;
          3'h2: op_out = op_divide;
          3'h3: op_out = op_divide_unsigned;
          default: op_out = op_none;
        endcase
      end
      ROW_4: begin
        case (col)
          3'h0: op_out = op_add_trapping;
          3'h1: op_out = op_add_wrapping;
          3'h2: op_out = op_sub_trapping;
          3'h3: op_out = op_sub_wrapping;
          3'h4: op_out = op_logic_and;
          3'h5: op_out = op_logic_or;
          3'h6: op_out = op_logic_xor;
          default: op_out = op_logic_nor;
        endcase
      end
      ROW_5: begin
        case (col)
          3'h2: op_out = op_set_less;
          3'h3: op_out = op_set_less_unsigned;
          default: op_out = op_none;
        endcase
      end
      ROW_6: begin
        // traps only from level two; level one leaves the row empty
        if (lvl_two_plus) begin
          case (col)
            3'h0: op_out = op_trap_greater_equal;
            3'h1: op_out = op_trap_ge_unsigned;
            3'h2: op_out = op_trap_less;
            3'h3: op_out = op_trap_less_unsigned;
            3'h4: op_out = op_trap_equal;
            3'h6: op_out = op_trap_not_equal;
            default: op_out = op_none;
          endcase
        end
      end
      default: op_out = op_none; // 64-bit shifts are outside this decoder
    endcase
  end

  assign reserved_out = (op_out == op_none);

endmodule // cod_func_decoder

// >>> sim/cod_fetch_model.sv
`timescale 1ns/10ps
// ****************************************************************
// fetch side model: hands one instruction word per cycle to decode
// ****************************************************************
module cod_fetch_model (
  // pipeline clock
  input wire logic clk_in,
  // word and level toward the decoder
  output logic [31:0] instr_out,
  output cod_pkg::cod_level_t level_out
);
  import cod_pkg::*;

  // idle fetch shows a bubble pattern, not zeros, so stale decode cannot pass
  initial begin
    instr_out = 32'hffff_ffff;
    level_out = lvl_one;
  end

  // launches a whole aligned word just after an edge, the way fetch would
  task automatic issue(input logic [31:0] word, input cod_level_t lvl);
    @(posedge clk_in);
    #1;
    instr_out = word;
    level_out = lvl;
  endtask
endmodule // cod_fetch_model

// >>> sim/tb_cod_opcode_decoder.sv
`timescale 1ns/10ps
// ****************************************************************
// self-checking bench for the opcode decoder
// ****************************************************************
module tb_cod_opcode_decoder;
  import cod_pkg::*;

  localparam cod_op_t N = op_none; // short name keeps the tables readable
  logic clk; // 50 MHz pipeline clock
  logic rst; // synchronous reset, only gates the checks
  logic [31:0] instr; // word from the fetch model
  cod_level_t level; // level from the fetch model
  cod_op_t op; // decoded identity
  logic [1:0] cop_num; // coprocessor number
  logic reserved; // reserved-instruction flag
  int errors = 0; // mismatch count
  int tests_run = 0; // comparison count
  // level one opcode table, row by row; classes at row 0 use zero low fields
  cod_op_t otab1 [64] = '{
    op_shift_left_logical, op_branch_lt_zero, op_jump_abs, op_jump_abs_link,
    op_branch_equal, op_branch_not_equal, op_branch_le_zero, op_branch_gt_zero,
    op_add_imm_trapping, op_add_imm_wrapping, op_set_less_imm, op_set_less_imm_unsigned,
    op_and_imm, op_or_imm, op_xor_imm, op_load_upper_imm,
    op_coproc0_class, op_coproc1_class, op_coproc2_class, op_coproc3_class, N, N, N, N,
    N, N, N, N, N, N, N, N,
    op_load_byte, op_load_half, op_load_word_left, op_load_word,
    op_load_byte_unsigned, op_load_half_unsigned, op_load_word_right, N,
    op_store_byte, op_store_half, op_store_word_left, op_store_word,
    N, N, op_store_word_right, N,
    N, op_cop_load_word, op_cop_load_word, op_cop_load_word, N, N, N, N,
    N, op_cop_store_word, op_cop_store_word, op_cop_store_word, N, N, N, N};
  // level one function table
  cod_op_t ftab1 [64] = '{
    op_shift_left_logical, N, op_shift_right_logical, op_shift_right_arith,
    op_shift_left_logical_var, N, op_shift_right_logical_var, op_shift_right_arith_var,
    op_jump_register, op_jump_register_link, N, N, op_system_call, op_breakpoint, N, N,
    op_move_from_hi, op_move_to_hi, op_move_from_lo, op_move_to_lo, N, N, N, N,
    op_multiply, op_multiply_unsigned, op_divide, op_divide_unsigned, N, N, N, N,
    op_add_trapping, op_add_wrapping, op_sub_trapping, op_sub_wrapping,
    op_logic_and, op_logic_or, op_logic_xor, op_logic_nor,
    N, N, op_set_less, op_set_less_unsigned, N, N, N, N,
    N, N, N, N, N, N, N, N, N, N, N, N, N, N, N, N};
  cod_op_t otab2 [64]; // level two opcode table, built from level one
  cod_op_t ftab2 [64]; // level two function table

  // ****************************************************************
  // clock, fetch model and decoder
  // ****************************************************************
  initial clk = 1'b0;
  // free-running clock, half period 10 ns
  always #10 clk = ~clk;

  cod_fetch_model i_cod_fetch_model (
    .clk_in(clk),
    .instr_out(instr),
    .level_out(level)
  );

  cod_opcode_decoder i_cod_opcode_decoder (
    .CLK_IN(clk),
    .RST_IN(rst),
    .INSTR_IN(instr),
    .LEVEL_IN(level),
    .OP_OUT(op),
    .COP_NUM_OUT(cop_num),
    .RESERVED_OUT(reserved)
  );

  // ****************************************************************
  // compare and drive helpers
  // ****************************************************************
  // identity compare; enum names make a mismatch readable
  task automatic cmp_op(input cod_op_t got, input cod_op_t exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: op %s expected %s", $time, got.name(), exp.name());
    end
  endtask

  // small field compare for the flag and the coprocessor number
  task automatic cmp_val(input logic [1:0] got, input logic [1:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s is %h expected %h", $time, what, got, exp);
    end
  endtask

  // one word per cycle; decode is combinational so it is judged mid-cycle
  task automatic decode(input logic [31:0] w, input cod_level_t l, input cod_op_t e);
    logic is_cop;
    is_cop = e inside {[op_coproc0_class:op_coproc3_class],
                       [op_cop_load_word:op_cop_store_double]};
    i_cod_fetch_model.issue(w, l);
    @(negedge clk);
    cmp_op(op, e);
    cmp_val({1'b0, reserved}, {1'b0, e == N}, "reserved");
    // the number only means something for coprocessor entries and refusals
    if (is_cop || e == N) begin
      cmp_val(cop_num, is_cop ? w[27:26] : 2'h0, "cop number");
    end
  endtask

  // sweeps all 64 opcodes; non-class words carry junk low bits on purpose
  task automatic run_otab(input cod_level_t l, input cod_op_t t [64]);
    for (int i = 0; i < 64; i++) begin
      decode({6'(i), (i < 2) ? 26'h0 : 26'h2a5_a5a5}, l, t[i]);
    end
  endtask

  // sweeps all 64 function codes with nonzero register and shift fields
  task automatic run_ftab(input cod_level_t l, input cod_op_t t [64]);
    for (int i = 0; i < 64; i++) begin
      decode({6'h00, 20'ha5a5a, 6'(i)}, l, t[i]);
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // decode must work while reset is high and change every cycle
  task automatic t_reset_decode();
    decode(32'h0000_0020, lvl_one, op_add_trapping);
    decode(32'h2000_0000, lvl_two, op_add_imm_trapping);
    $display("test reset_decode done");
  endtask

  // first level: full opcode and function tables, gaps must be refused
  task automatic t_level_one();
    run_otab(lvl_one, otab1);
    run_ftab(lvl_one, ftab1);
    $display("test level_one done");
  endtask

  // second level adds likely branches, linked pair, doubles, sync, traps
  task automatic t_level_two();
    otab2 = otab1;
    for (int c = 0; c < 4; c++) begin
      otab2[20 + c] = cod_op_t'(int'(op_branch_equal_likely) + c);
    end
    otab2[48] = op_load_linked;
    otab2[56] = op_store_conditional;
    for (int c = 5; c < 8; c++) begin
      otab2[48 + c] = op_cop_load_double;
      otab2[56 + c] = op_cop_store_double;
    end
    ftab2 = ftab1;
    ftab2[15] = op_memory_sync;
    for (int c = 0; c < 5; c++) begin
      ftab2[48 + c] = cod_op_t'(int'(op_trap_greater_equal) + c);
    end
    ftab2[54] = op_trap_not_equal;
    run_otab(lvl_two, otab2);
    run_ftab(lvl_two, ftab2);
    $display("test level_two done");
  endtask

  // later levels drop every coprocessor 3 slot; the top one reuses the class slot
  task automatic t_later_levels();
    cod_op_t t [64];
    t = otab2;
    t[19] = N;
    t[51] = N;
    t[55] = N;
    t[59] = N;
    t[63] = N;
    run_otab(lvl_three, t);
    t[19] = op_fpu_extended_class;
    run_otab(lvl_four, t);
    run_ftab(lvl_three, ftab2);
    run_ftab(lvl_four, ftab2);
    $display("test later_levels done");
  endtask

  // reg-imm class: all 32 rt codes at every level, other fields busy
  task automatic t_reg_imm();
    cod_op_t e;
    for (int l = 0; l < 4; l++) begin
      for (int r = 0; r < 32; r++) begin
        case (r)
          0: e = op_branch_lt_zero;
          1: e = op_branch_ge_zero;
          16: e = op_branch_lt_zero_link;
          17: e = op_branch_ge_zero_link;
          default: e = N;
        endcase
        decode({6'h01, 5'h15, 5'(r), 16'hbeef}, cod_level_t'(l), e);
      end
    end
    $display("test reg_imm done");
  endtask

  // ****************************************************************
  // verdict and main sequence
  // ****************************************************************
  // single exit point for both the normal end and the watchdog
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // about 700 cycles of work; the limit leaves ample margin
  initial begin
    #100000;
    errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_of_test();
  end

  // reset spans 20 cycles; the first two decode during it
  initial begin
    rst = 1'b1;
    t_reset_decode();
    repeat (18) @(posedge clk);
    #1;
    rst = 1'b0;
    t_level_one();
    t_level_two();
    t_later_levels();
    t_reg_imm();
    end_of_test();
  end
endmodule // tb_cod_opcode_decoder
